// ==== rtl/cal_ctrl_defines.vh ====
/*
 * register indices, field positions, reset values and step times in ns of the
 * calibration control block; assumes inclusion by bare name from rtl/.
 */
`ifndef CAL_CTRL_DEFINES_VH
`define CAL_CTRL_DEFINES_VH

// ****************************************************************
// register indices as printed, byte address is index times four
// ****************************************************************
`define IDX_RUN_CTRL 8'h61
`define IDX_MODE_CFG 8'h62
`define IDX_OFFSET_REFERENCE_SELECT_CFG 8'h65
`define IDX_TUNE_STATUS 8'h5E
`define IDX_LOOP_CTRL 8'h5C
`define IDX_TUNE_CTRL 8'h5D
`define IDX_TRIM 8'h5B
`define IDX_CAL_STATUS 8'h6A
`define IDX_IRQ_STATUS 8'h70
`define IDX_IRQ_MASK 8'h71

// ****************************************************************
// reset values
// ****************************************************************
`define RST_RUN_CTRL 8'h01
`define RST_MODE_CFG 8'h01
`define RST_OFFSET_REFERENCE_SELECT_CFG 8'h01
`define RST_LOOP_CTRL 8'h00
`define RST_TUNE_CTRL 8'h00
`define RST_TRIM 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_BGOS 3
`define BIT_FGOS 2
`define BIT_BG 1
`define BIT_FG 0
`define BIT_OFFSET_REFERENCE_SELECT 2
`define BIT_IRQ_TUNE 0
`define BIT_IRQ_FG 1
`define BIT_IRQ_OS 2

// ****************************************************************
// timing: length of each engine step in ns at 8 ns clock
// ****************************************************************
`define CLK_PERIOD_NS 8
`define FG_TIME_NS 400
`define OS_TIME_NS 200
`define TUNE_TIME_NS 160

`endif

// ==== rtl/adc_calibration_control.v ====
/*
 * calibration control and status for a multi-channel converter, with an
 * apb slave for the registers, a vco tuning sequencer and interrupt logic.
 * assumes one clock pclk at 125 MHz and asynchronous active-low presetn;
 * software follows the register programming order of the device.
 */
`timescale 1ns/1ps
`include "cal_ctrl_defines.vh"

module adc_calibration_control #(
    parameter FG_CYCLES = (`FG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter OS_CYCLES = (`OS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter TUNE_CYCLES = (`TUNE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire pclk, // apb clock
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error on unmapped address
    output reg cal_reset_n, // calibration logic reset, active low
    output reg divider_reset_n, // digital and link divider reset, active low
    output reg fg_active, // foreground calibration running
    output reg os_active, // foreground offset calibration running
    output reg bg_active, // background calibration running
    output reg bg_offset_active, // background offset calibration running
    output reg offset_ref_spare, // offset target is the spare converter
    output reg [6:0] freq_trim, // oscillator frequency trim
    output reg irq // level interrupt
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_FG = 3'd1;
    localparam [2:0] ST_OS = 3'd2;
    localparam [2:0] ST_RUN = 3'd3;
    localparam [2:0] ST_DONE = 3'd4;
    localparam [1:0] TS_IDLE = 2'd0;
    localparam [1:0] TS_RUN = 2'd1;
    localparam [1:0] TS_DONE = 2'd2;

    reg [7:0] run_ctrl;
    reg [7:0] mode_cfg;
    reg [7:0] offset_reference_select_cfg;
    reg [7:0] loop_ctrl;
    reg [7:0] tune_ctrl;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    reg [2:0] state;
    reg [1:0] tstate;
    reg [15:0] count;
    reg [15:0] tcount;
    reg run_q;
    reg loop_q;
    reg fg_done;
    reg fg_done_q;
    reg os_done;
    reg os_done_q;
    reg tune_done;
    reg tune_done_q;
    reg [31:0] next_prdata;
    reg next_err;
    reg [9:0] idx;

    wire run_bit = run_ctrl[0];
    wire access = psel && penable && pready;
    wire wr = access && pwrite && !next_err;
    wire tune_complete = (tstate == TS_DONE) || !tune_ctrl[0];
    wire [2:0] events = {os_done && !os_done_q, fg_done && !fg_done_q,
                         tune_done && !tune_done_q};

    // ****************************************************************
    // apb read decode
    // ****************************************************************
    always @*
    begin
        idx = paddr[11:2];
        next_err = 1'b0;
        next_prdata = 32'h0000_0000;
        if (paddr[1:0] != 2'b00)
            next_err = 1'b1;
        else if (idx == {2'b00, `IDX_RUN_CTRL})
            next_prdata = {24'h000000, run_ctrl};
        else if (idx == {2'b00, `IDX_MODE_CFG})
            next_prdata = {24'h000000, mode_cfg};
        else if (idx == {2'b00, `IDX_OFFSET_REFERENCE_SELECT_CFG})
            next_prdata = {24'h000000, offset_reference_select_cfg};
        else if (idx == {2'b00, `IDX_TUNE_STATUS})
            next_prdata = {31'h0000_0000, tune_complete};
        else if (idx == {2'b00, `IDX_LOOP_CTRL})
            next_prdata = {24'h000000, loop_ctrl};
        else if (idx == {2'b00, `IDX_TUNE_CTRL})
            next_prdata = {24'h000000, tune_ctrl};
        else if (idx == {2'b00, `IDX_TRIM})
            next_prdata = {25'h0000000, freq_trim};
        else if (idx == {2'b00, `IDX_CAL_STATUS})
            next_prdata = {29'h00000000, state == ST_RUN, os_done, fg_done};
        else if (idx == {2'b00, `IDX_IRQ_STATUS})
            next_prdata = {29'h00000000, irq_status};
        else if (idx == {2'b00, `IDX_IRQ_MASK})
            next_prdata = {29'h00000000, irq_mask};
        else
            next_err = 1'b1;
    end

    // ****************************************************************
    // apb slave: one wait state, answer in the second access cycle
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready)
            begin
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
                pslverr <= next_err;
            end
            else
            begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // writable registers
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_ctrl <= `RST_RUN_CTRL;
            mode_cfg <= `RST_MODE_CFG;
            offset_reference_select_cfg <= `RST_OFFSET_REFERENCE_SELECT_CFG;
            loop_ctrl <= `RST_LOOP_CTRL;
            tune_ctrl <= `RST_TUNE_CTRL;
            irq_mask <= 3'h0;
        end
        else if (wr)
        begin
            if (idx == {2'b00, `IDX_RUN_CTRL})
                run_ctrl <= pwdata[7:0];
            else if (idx == {2'b00, `IDX_MODE_CFG})
                mode_cfg <= pwdata[7:0];
            else if (idx == {2'b00, `IDX_OFFSET_REFERENCE_SELECT_CFG})
                offset_reference_select_cfg <= pwdata[7:0];
            else if (idx == {2'b00, `IDX_LOOP_CTRL})
                loop_ctrl <= pwdata[7:0];
            else if (idx == {2'b00, `IDX_TUNE_CTRL})
                tune_ctrl <= pwdata[7:0];
            else if (idx == {2'b00, `IDX_IRQ_MASK})
                irq_mask <= pwdata[2:0];
        end
    end

    // ****************************************************************
    // vco tuning engine
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tstate <= TS_IDLE;
            tcount <= 16'h0000;
            loop_q <= 1'b0;
            freq_trim <= 7'h00;
            tune_done <= 1'b0;
            tune_done_q <= 1'b0;
        end
        else
        begin
            loop_q <= loop_ctrl[0];
            tune_done_q <= tune_done;
            tune_done <= (tstate == TS_DONE);
            if (loop_ctrl[0])
            begin
                tstate <= TS_IDLE;
                tcount <= 16'h0000;
            end
            else
            begin
                case (tstate)
                    TS_IDLE:
                    begin
                        if (loop_q && tune_ctrl[0])
                        begin
                            tstate <= TS_RUN;
                            freq_trim <= 7'h40;
                            tcount <= 16'h0000;
                        end
                    end
                    TS_RUN:
                    begin
                        // trim parks at mid-scale; the search itself is left to the analog loop
                        if (tcount == TUNE_CYCLES[15:0] - 16'h0001)
                            tstate <= TS_DONE;
                        else
                            tcount <= tcount + 16'h0001;
                    end
                    default:
                        tstate <= tstate;
                endcase
            end
            // trim writes during a run are dropped to protect the engine
            if (wr && idx == {2'b00, `IDX_TRIM} && tstate != TS_RUN)
                freq_trim <= pwdata[6:0];
        end
    end

    // ****************************************************************
    // calibration sequencer
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            count <= 16'h0000;
            run_q <= 1'b0;
            fg_done <= 1'b0;
            fg_done_q <= 1'b0;
            os_done <= 1'b0;
            os_done_q <= 1'b0;
        end
        else
        begin
            run_q <= run_bit;
            fg_done_q <= fg_done;
            os_done_q <= os_done;
            if (!run_bit)
            begin
                state <= ST_IDLE;
                count <= 16'h0000;
                fg_done <= 1'b0;
                os_done <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (!run_q)
                        begin
                            count <= 16'h0000;
                            state <= mode_cfg[`BIT_FG] ? ST_FG : ST_DONE;
                            fg_done <= !mode_cfg[`BIT_FG];
                        end
                    end
                    ST_FG:
                    begin
                        if (count == FG_CYCLES[15:0] - 16'h0001)
                        begin
                            fg_done <= 1'b1;
                            count <= 16'h0000;
                            state <= mode_cfg[`BIT_FGOS] ? ST_OS : ST_DONE;
                        end
                        else
                            count <= count + 16'h0001;
                    end
                    ST_OS:
                    begin
                        if (count == OS_CYCLES[15:0] - 16'h0001)
                        begin
                            os_done <= 1'b1;
                            state <= ST_DONE;
                        end
                        else
                            count <= count + 16'h0001;
                    end
                    ST_DONE:
                        state <= mode_cfg[`BIT_BG] ? ST_RUN : ST_DONE;
                    default:
                        state <= mode_cfg[`BIT_BG] ? ST_RUN : ST_DONE;
                endcase
            end
        end
    end

    // ****************************************************************
    // registered control outputs and interrupt
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_reset_n <= 1'b0;
            divider_reset_n <= 1'b0;
            fg_active <= 1'b0;
            os_active <= 1'b0;
            bg_active <= 1'b0;
            bg_offset_active <= 1'b0;
            offset_ref_spare <= 1'b0;
            irq_status <= 3'h0;
            irq <= 1'b0;
        end
        else
        begin
            cal_reset_n <= run_bit;
            divider_reset_n <= run_bit;
            fg_active <= (state == ST_FG);
            os_active <= (state == ST_OS);
            bg_active <= (state == ST_RUN);
            // background offset needs background running too
            bg_offset_active <= (state == ST_RUN) && mode_cfg[`BIT_BGOS];
            offset_ref_spare <= offset_reference_select_cfg[`BIT_OFFSET_REFERENCE_SELECT];
            // set wins over a same-cycle write-one clear
            if (wr && idx == {2'b00, `IDX_IRQ_STATUS})
                irq_status <= (irq_status & ~pwdata[2:0]) | events;
            else
                irq_status <= irq_status | events;
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule // adc_calibration_control

// ==== bench/cal_ctrl_monitor.sv ====
/*
 checker of the calibration control ports.
 assumes it is bound to adc_calibration_control, one clock, async low reset.
*/
`timescale 1ns/1ps
module cal_ctrl_monitor #(
    parameter int FG_CYCLES = 2,
    parameter int OS_CYCLES = 2
) (
    input wire pclk, // clock
    input wire presetn, // reset, active low
    input wire psel, // select
    input wire penable, // access phase
    input wire pwrite, // direction
    input wire [11:0] paddr, // byte address
    input wire [31:0] prdata, // read data
    input wire pready, // ready
    input wire cal_reset_n, // calibration reset
    input wire divider_reset_n, // divider reset
    input wire fg_active, // foreground running
    input wire os_active, // offset running
    input wire bg_active, // background running
    input wire bg_offset_active, // background offset running
    input wire offset_ref_spare // spare reference
);
    // ****************************************************************
    // properties
    // ****************************************************************
    // a step must end within its count; the active flag is seen one cycle late at both ends
    localparam int FG_MAX = FG_CYCLES;
    localparam int OS_MAX = OS_CYCLES;
    wire wr_offset_reference_select = psel && penable && pready && pwrite && paddr == 12'h194;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        ##1 !pready ##1 pready;
    endsequence
    chk_apb_answer: assert property (setup_s |-> answer_s)
        else $error("apb answer out of place");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_divider_follows: assert property (cal_reset_n == divider_reset_n)
        else $error("divider reset differs from calibration reset");
    chk_hold_idle: assert property (!cal_reset_n && !$past(cal_reset_n) |->
        !(fg_active || os_active || bg_active || bg_offset_active))
        else $error("calibration runs while held");
    chk_fg_length: assert property ($rose(fg_active) |-> ##[1:FG_MAX] !fg_active)
        else $error("foreground too long");
    chk_os_length: assert property ($rose(os_active) |-> ##[1:OS_MAX] !os_active)
        else $error("offset step too long");
    chk_step_order: assert property (bg_active |-> !fg_active && !os_active)
        else $error("background overlaps foreground");
    chk_bgos_needs_bg: assert property (bg_offset_active |-> bg_active)
        else $error("background offset without background");
    chk_spare_write: assert property ($changed(offset_ref_spare) |->
        $past(wr_offset_reference_select) || $past(wr_offset_reference_select, 2))
        else $error("reference select changed without write");
endmodule // cal_ctrl_monitor

bind adc_calibration_control cal_ctrl_monitor #(.FG_CYCLES(FG_CYCLES), .OS_CYCLES(OS_CYCLES))
    mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .cal_reset_n(cal_reset_n),
    .divider_reset_n(divider_reset_n), .fg_active(fg_active), .os_active(os_active),
    .bg_active(bg_active), .bg_offset_active(bg_offset_active),
    .offset_ref_spare(offset_ref_spare));

// ==== bench/adc_calibration_control_tb.sv ====
/*
 self-checking bench of adc_calibration_control driven over apb.
 assumes the checker binds itself to the design; one 125 MHz clock.
*/
`timescale 1ns/1ps
module adc_calibration_control_tb;
    // ****************************************************************
    // signals and design
    // ****************************************************************
    localparam logic [11:0] A_RUN = 12'h184, A_MODE = 12'h188, A_OSR = 12'h194;
    localparam logic [11:0] A_TST = 12'h178, A_LOOP = 12'h170, A_TCT = 12'h174;
    localparam logic [11:0] A_TRIM = 12'h16C, A_CST = 12'h1A8, A_IST = 12'h1C0;
    localparam logic [11:0] A_IMSK = 12'h1C4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, cal_reset_n, divider_reset_n, fg_active, os_active;
    logic bg_active, bg_offset_active, offset_ref_spare, irq;
    logic [6:0] freq_trim;
    logic [9:0] exp_q[$];
    logic [9:0] e;
    logic [7:0] tv;
    logic [7:0] modes [4] = '{8'h00, 8'h03, 8'h07, 8'h0F};
    logic [7:0] stats [4] = '{8'h01, 8'h05, 8'h07, 8'h07};
    int n_fail = 0, num_checks = 0, cyc = 0;
    adc_calibration_control #(.FG_CYCLES(4), .OS_CYCLES(3), .TUNE_CYCLES(20)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cal_reset_n(cal_reset_n), .divider_reset_n(divider_reset_n), .fg_active(fg_active),
        .os_active(os_active), .bg_active(bg_active), .bg_offset_active(bg_offset_active),
        .offset_ref_spare(offset_ref_spare), .freq_trim(freq_trim), .irq(irq));
    initial forever #4 pclk = ~pclk;
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // the expected answer is noted before the request goes out
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [7:0] ex, input logic er);
        exp_q.push_back({er, w, ex});
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // no local limit: only the bench timeout ends a wait for the answer
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1, a, {24'h0, d}, 8'h00, 0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] ex);
        apb(0, a, 32'h0, ex, 0);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************************************
    // answer watcher and timeout
    // ****************************************************************
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_fail++;
            end_sim;
        end
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check(pslverr, e[9]);
            if (!e[8])
                check(prdata, {24'h0, e[7:0]});
        end
    end
    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        void'($urandom(54159));
        waitc(4);
        presetn <= 1;
        rd(A_RUN, 8'h01);
        rd(A_MODE, 8'h01);
        rd(A_OSR, 8'h01);
        rd(A_TST, 8'h01);
        rd(A_IMSK, 8'h00);
        apb(0, 12'hFFC, 32'h0, 8'h00, 1);
        apb(1, 12'h185, 32'h0, 8'h00, 1);
        check(cal_reset_n, 1);
        check(divider_reset_n, 1);
        waitc(20);
        rd(A_CST, 8'h01);
        $display("reset and register test done");
        for (int i = 0; i < 4; i++)
        begin
            wr(A_RUN, 8'h00);
            waitc(2);
            check(cal_reset_n, 0);
            check(divider_reset_n, 0);
            rd(A_CST, 8'h00);
            wr(A_MODE, modes[i]);
            wr(A_RUN, 8'h01);
            waitc(2);
            check(fg_active, modes[i][0]);
            waitc(28);
            rd(A_CST, stats[i]);
            check(bg_active, modes[i][1]);
            check(bg_offset_active, modes[i][3]);
        end
        $display("sequence test done");
        wr(A_OSR, 8'h05);
        waitc(2);
        check(offset_ref_spare, 1);
        wr(A_OSR, 8'h01);
        waitc(2);
        check(offset_ref_spare, 0);
        $display("offset reference test done");
        wr(A_IMSK, 8'h01);
        wr(A_IST, 8'h07);
        waitc(2);
        check(irq, 0);
        wr(A_LOOP, 8'h01);
        wr(A_TCT, 8'h01);
        rd(A_TST, 8'h00);
        wr(A_LOOP, 8'h00);
        rd(A_TRIM, 8'h40);
        wr(A_TRIM, 8'h11);
        rd(A_TRIM, 8'h40);
        rd(A_TST, 8'h00);
        waitc(25);
        rd(A_TST, 8'h01);
        check(irq, 1);
        wr(A_IMSK, 8'h00);
        waitc(2);
        check(irq, 0);
        wr(A_IMSK, 8'h01);
        waitc(2);
        check(irq, 1);
        wr(A_IST, 8'h01);
        waitc(2);
        check(irq, 0);
        tv = 8'($urandom) & 8'h7F;
        wr(A_TRIM, tv);
        rd(A_TRIM, tv);
        check(freq_trim, tv[6:0]);
        $display("tuning and interrupt test done");
        // reset in mid-run must bring back the reset values of both resets, trim, mode and tune status
        presetn <= 0;
        waitc(2);
        check(cal_reset_n, 0);
        check(divider_reset_n, 0);
        check(freq_trim, 0);
        presetn <= 1;
        rd(A_MODE, 8'h01);
        rd(A_TST, 8'h01);
        rd(A_TRIM, 8'h00);
        check(cal_reset_n, 1);
        check(exp_q.size(), 0);
        $display("mid-run reset test done");
        end_sim;
    end
endmodule // adc_calibration_control_tb
